/* File: hdl/act_regs.svh */
// constants for the converter trigger and sequencing control block
`ifndef ACT_REGS_SVH
`define ACT_REGS_SVH
// ===========================================================================
// mode encodings of sequence_mode_field
`define ACT_SEQ_SINGLE     2'h0
`define ACT_SEQ_SEQUENCE   2'h1
`define ACT_SEQ_REPEAT_ONE 2'h2
`define ACT_SEQ_REPEAT_SEQ 2'h3
// ===========================================================================
// control word a bit positions
`define ACT_CWA_ENC_POS 1
`define ACT_CWA_ON_POS  4
`define ACT_CWA_SC_POS  0
// ===========================================================================
// reset values and timing
`define ACT_CWA_RESET   16'h0000
`define ACT_CONV_CYCLES 8'h10
`define ACT_SEQ_LEN     4'h4
`endif

/* File: hdl/act_pkg.sv */
// types for the converter trigger and sequencing control block
`default_nettype none
package act_pkg;
  typedef enum logic [1:0] {
    act_idle   = 2'b00,
    act_busy   = 2'b01,
    act_halted = 2'b10
  } act_state_t;

  typedef struct packed {
    logic        write_strobe;
    logic [15:0] write_data;
  } act_ctl_write_t;

  typedef struct packed {
    logic        busy;
    logic        halted;
    logic        overrun;
    logic        result_valid;
    logic [3:0]  channel;
  } act_status_t;

  typedef struct packed {
    act_state_t  state;
    logic [15:0] converter_control_word_a;
    logic        armed;
    logic [7:0]  cycle_count;
    logic [3:0]  channel;
    logic        result_valid;
    logic        overrun;
    logic [2:0]  trig_sync;
    logic        trig_level;
  } act_regs_t;
endpackage
`default_nettype wire

/* File: hdl/act_core.sv */
// converter conversion start, sequencing and halt control
// How it works
// [RQ1] single mode, timer trigger: any control word a write arms a sample
// [RQ2] intended arming only by setting enable conversion; defect overrides that
// [RQ3] software clears enable conversion before other control word a writes
// [RQ4] software then sets enable conversion to rearm for next timer trigger
// [RQ5] starts come from software start bit or selected timer output
// [RQ6] trigger while busy halts all later conversions until disable and reenable
// [RQ7] halt only in sequence, repeat single and repeat sequence modes
// [RQ8] overrun flag does not reliably report triggers arriving while busy
// [RQ9] software polls busy flag before issuing a software start
// [RQ10] timer period must exceed sample plus conversion time
// [RQ11] recovery: clear enable and power, set power and enable, restart
// [RQ12] busy flag set from accepted start until result is complete
`include "act_regs.svh"
`default_nettype none
module act_core
  import act_pkg::*;
#(
  parameter logic [7:0] CONV_CYCLES = `ACT_CONV_CYCLES,
  parameter logic [3:0] SEQ_LEN     = `ACT_SEQ_LEN
)(
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // control word a write port from the cpu
  input  wire act_pkg::act_ctl_write_t ctl_write,
  // control word b configuration
  input  wire logic [1:0]              sequence_mode_field,
  input  wire logic                    sample_timer_select,
  // timer trigger pin, asynchronous
  input  wire logic                    timer_trigger,
  // readback and status
  output logic [15:0]                  converter_control_word_a,
  output act_pkg::act_status_t         status,
  output logic                         converter_busy_flag,
  output logic                         trigger_overrun_flag
);
  import act_pkg::*;

  // ===========================================================================
  // state and working signals
  // the whole block state lives in one struct so reset and update stay in step
  act_regs_t r;
  act_regs_t next_r;

  logic enc_now;
  logic on_now;
  logic enc_rise;
  logic arm_set;
  logic trig_edge;
  logic sw_start;
  logic start;
  logic repeat_mode;

  // ===========================================================================
  // helpers
  // true for the modes that suffer the busy trigger halt; single mode simply
  // ignores a start that lands while it is converting
  function automatic logic halt_mode(input logic [1:0] m);
    halt_mode = (m != `ACT_SEQ_SINGLE);
  endfunction

  // ===========================================================================
  // next state
  always_comb
  begin
    next_r      = r;
    enc_now     = r.converter_control_word_a[`ACT_CWA_ENC_POS];
    on_now      = r.converter_control_word_a[`ACT_CWA_ON_POS];
    enc_rise    = 1'b0;
    arm_set     = 1'b0;
    sw_start    = 1'b0;
    repeat_mode = sequence_mode_field[1];
    // three stage sync; edge counted once stages two and three agree
    // a pin pulse shorter than two clock periods can slip through unseen
    next_r.trig_sync = {r.trig_sync[1:0], timer_trigger};
    if (r.trig_sync[2] == r.trig_sync[1])
    begin
      next_r.trig_level = r.trig_sync[2];
    end
    trig_edge = (r.trig_sync[2] == r.trig_sync[1]) && r.trig_sync[2] && !r.trig_level;
    // the word is taken on the strobe, all but the start bit
    if (ctl_write.write_strobe)
    begin
      next_r.converter_control_word_a = ctl_write.write_data;
      next_r.converter_control_word_a[`ACT_CWA_SC_POS] = 1'b0; // start bit self clears
      enc_rise = ctl_write.write_data[`ACT_CWA_ENC_POS] && !enc_now;
      // software start counts only with power and enable in the same word,
      // and is ignored while the timer is the selected source
      sw_start = ctl_write.write_data[`ACT_CWA_SC_POS]
                 && ctl_write.write_data[`ACT_CWA_ENC_POS]
                 && ctl_write.write_data[`ACT_CWA_ON_POS] && !sample_timer_select;
      // [RQ2] enable rise arms
      if (enc_rise)
      begin
        next_r.armed = 1'b1;
      end
      // [RQ1] defect any write arms
      if (sequence_mode_field == `ACT_SEQ_SINGLE && sample_timer_select)
      begin
        next_r.armed = 1'b1;
      end
      // a write that arms while leaving power and enable on
      arm_set = (enc_rise
                 || (sequence_mode_field == `ACT_SEQ_SINGLE && sample_timer_select))
                && ctl_write.write_data[`ACT_CWA_ENC_POS]
                && ctl_write.write_data[`ACT_CWA_ON_POS];
      // [RQ11] disable clears halt
      if (!ctl_write.write_data[`ACT_CWA_ENC_POS] || !ctl_write.write_data[`ACT_CWA_ON_POS])
      begin
        next_r.state = act_idle;
        next_r.armed = 1'b0;
      end
    end
    // [RQ5] two start sources; a software start carries its own enable and power,
    // a timer start needs them already set and the arm left by a write
    start = sw_start
            || (on_now && enc_now && sample_timer_select && trig_edge && r.armed);
    case (r.state)
      act_idle:
      begin
        // accept a start unless a disabling write lands in the same cycle
        if (start && next_r.state == act_idle)
        begin
          next_r.state        = act_busy;
          next_r.cycle_count  = CONV_CYCLES;
          next_r.channel      = 4'h0;
          next_r.result_valid = 1'b0;
          // single mode consumes the timer arm; only rewrite rearms, and a
          // write that arms in this very cycle wins over the consumption
          if (sequence_mode_field == `ACT_SEQ_SINGLE)
          begin
            next_r.armed = arm_set;
          end
        end
      end
      act_busy:
      begin
        // [RQ6] trigger while busy halts
        // [RQ7] single mode exempt
        if (start && halt_mode(sequence_mode_field))
        begin
          next_r.state = act_halted;
          // [RQ8] overrun flag unreliable, left unset
          next_r.overrun = r.overrun;
        end
        else if (r.cycle_count == 8'h01)
        begin
          // last cycle of a channel: result lands, then step, repeat or stop
          next_r.result_valid = 1'b1;
          // sequence modes walk the channels up to the last one
          if (sequence_mode_field[0] && r.channel != SEQ_LEN - 4'h1)
          begin
            next_r.channel     = r.channel + 4'h1;
            next_r.cycle_count = CONV_CYCLES;
          end
          else if (repeat_mode && enc_now)
          begin
            // repeat modes start over only while enable stays set
            next_r.channel     = 4'h0;
            next_r.cycle_count = CONV_CYCLES;
          end
          else
          begin
            next_r.state = act_idle;
          end
        end
        else
        begin
          next_r.cycle_count = r.cycle_count - 8'h01;
        end
        // a run that ends as enable drops stays idle
        if (next_r.state == act_idle && ctl_write.write_strobe && !enc_now)
        begin
          next_r.state = act_idle;
        end
      end
      act_halted:
      begin
        // a halted converter ignores every start; busy stays low
        next_r.state = act_halted; // left only by disable
      end
      default:
      begin
        // unused code falls back to idle
        next_r.state = act_idle;
      end
    endcase
    // [RQ11] a write dropping enable or power always wins, even over a halt
    // raised at the same edge: nothing is left to convert once it is off
    if (ctl_write.write_strobe
        && (!ctl_write.write_data[`ACT_CWA_ENC_POS] || !ctl_write.write_data[`ACT_CWA_ON_POS]))
    begin
      next_r.state = act_idle;
    end
  end

  // ===========================================================================
  // state register
  // the reset branch loads constants only
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      r <= '{state: act_idle, converter_control_word_a: `ACT_CWA_RESET, default: '0};
    end
    else
    begin
      r <= next_r;
    end
  end

  // ===========================================================================
  // outputs
  // control word, overrun, result valid and channel read straight from flops; busy and halted are decoded from the state register
  assign converter_control_word_a = r.converter_control_word_a;
  // [RQ12] busy from start to result
  assign converter_busy_flag      = (r.state == act_busy);
  assign trigger_overrun_flag     = r.overrun;
  assign status = '{busy: (r.state == act_busy), halted: (r.state == act_halted),
                    overrun: r.overrun, result_valid: r.result_valid, channel: r.channel};
endmodule
`default_nettype wire

/* File: testbench/act_core_properties.sv */
// assertions on the converter trigger control ports
`default_nettype none
module act_core_properties
  import act_pkg::*;
#(
  parameter logic [7:0] CONV_CYCLES = 8'h10,
  parameter logic [3:0] SEQ_LEN     = 4'h4
)(
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    rst,
  // watched ports
  input wire act_pkg::act_ctl_write_t ctl_write,
  input wire logic [1:0]              sequence_mode_field,
  input wire logic                    sample_timer_select,
  input wire act_pkg::act_status_t    status,
  input wire logic                    converter_busy_flag,
  input wire logic                    trigger_overrun_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  logic [7:0] run;
  // powered and enabled software start
  wire logic go = ctl_write.write_strobe && !sample_timer_select
    && ctl_write.write_data[0] && ctl_write.write_data[1] && ctl_write.write_data[4];
  // busy stretch length, read when busy drops
  always_ff @(posedge mclk or posedge rst)
    run <= rst ? 8'h00 : (converter_busy_flag ? run + 8'h01 : 8'h00);
  chk_overrun_low: assert property (!trigger_overrun_flag)
    else $error("overrun flag set");
  chk_busy_mirror: assert property (status.busy == converter_busy_flag)
    else $error("status busy differs");
  chk_start_busy: assert property (
    go && !converter_busy_flag && !status.halted |-> ##[1:2] converter_busy_flag)
    else $error("start left busy low");
  chk_overlap_halts: assert property (
    go && converter_busy_flag && sequence_mode_field != 2'h0 |-> ##[1:2] status.halted)
    else $error("overlap did not halt");
  chk_single_no_halt: assert property (
    sequence_mode_field == 2'h0 && !status.halted |=> !status.halted)
    else $error("halt in single mode");
  chk_disable_recovers: assert property (
    ctl_write.write_strobe && !ctl_write.write_data[1]
    |-> ##[1:2] (!status.halted && !converter_busy_flag))
    else $error("disable did not clear");
  chk_busy_length: assert property (
    $fell(converter_busy_flag) && status.result_valid && sequence_mode_field == 2'h0
    |-> run == CONV_CYCLES)
    else $error("busy length wrong");
  chk_halt_sticks: assert property (
    status.halted && !(ctl_write.write_strobe
    && (!ctl_write.write_data[1] || !ctl_write.write_data[4])) |=> status.halted)
    else $error("halt left without disable");
endmodule
bind act_core act_core_properties #(.CONV_CYCLES(CONV_CYCLES), .SEQ_LEN(SEQ_LEN))
  act_core_properties_inst (.mclk, .rst, .ctl_write, .sequence_mode_field,
  .sample_timer_select, .status, .converter_busy_flag, .trigger_overrun_flag);
`default_nettype wire

/* File: testbench/act_timer_model.sv */
// timer output model: stretches a request into a short trigger pulse
`default_nettype none
module act_timer_model (
  // clock and request
  input  wire logic mclk,
  input  wire logic fire,
  // trigger pin
  output wire logic timer_trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold = 0;
  // three cycles high, long enough for the pin synchroniser
  always @(posedge mclk)
    hold <= fire ? 3 : (hold > 0 ? hold - 1 : 0);
  assign timer_trigger = hold != 0;
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the converter trigger control
`include "act_regs.svh"
`default_nettype none
module tb;
  import act_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic           mclk = 0, rst = 1, sts = 0, fire = 0, trig, busy, ovr;
  logic [1:0]     mode = 2'h0;
  logic [15:0]    word_a;
  act_ctl_write_t cw = '0;
  act_status_t    st;
  int             error_cnt = 0, checked = 0, cyc = 0;
  // 50 MHz clock
  always #10 mclk = ~mclk;
  act_core #(.CONV_CYCLES(8'h04)) act_core_inst (.mclk, .rst, .ctl_write(cw),
    .sequence_mode_field(mode), .sample_timer_select(sts), .timer_trigger(trig),
    .converter_control_word_a(word_a), .status(st), .converter_busy_flag(busy),
    .trigger_overrun_flag(ovr));
  act_timer_model act_timer_model_inst (.mclk, .fire, .timer_trigger(trig));
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle strobe, launched and dropped on falling edges
  task automatic wr(logic [15:0] d);
    @(negedge mclk);
    cw = '{1'b1, d};
    @(negedge mclk);
    cw.write_strobe = 1'b0;
  endtask
  task automatic pulse();
    @(negedge mclk);
    fire = 1'b1;
    @(negedge mclk);
    fire = 1'b0;
  endtask
  // bounded wait, so a stuck flag cannot hang the run
  task automatic wait_busy(logic v);
    repeat (12)
      if (busy !== v)
        @(negedge mclk);
    chk("busy", 16'(busy), 16'(v));
  endtask
  // software starts overlapping in every mode
  task automatic t_soft();
    for (int m = 0; m < 4; m++)
    begin
      mode = 2'(m);
      wait_busy(1'b0);
      wr(16'h0013);
      chk("busy", 16'(busy), 16'h1);
      chk("control word a", word_a, 16'h0012);
      wr(16'h0013);
      repeat (20) @(negedge mclk);
      chk("halted", 16'(st.halted), 16'(m != 0));
      // power and enable off, then back on
      wr(16'h0000);
      wr(16'h0012);
      chk("halted", 16'(st.halted), 16'h0);
    end
    // a clean sequence walks every channel, then drops busy
    mode = 2'h1;
    wr(16'h0013);
    repeat (20) @(negedge mclk);
    chk("busy", 16'(busy), 16'h0);
    chk("channel", 16'(st.channel), 16'(`ACT_SEQ_LEN - 4'h1));
    mode = 2'h0;
  endtask
  task automatic t_timer();
    sts = 1'b1;
    wr(16'h0013);
    chk("busy", 16'(busy), 16'h0);
    pulse();
    wait_busy(1'b1);
    // the next trigger comes only once the conversion is over
    wait_busy(1'b0);
    chk("result valid", 16'(st.result_valid), 16'h1);
    pulse();
    repeat (8) @(negedge mclk);
    chk("busy", 16'(busy), 16'h0);
    wr(16'h0012);
    pulse();
    wait_busy(1'b1);
    wait_busy(1'b0);
    // clear enable, then set it again
    mode = 2'h1;
    wr(16'h0010);
    wr(16'h0012);
    pulse();
    wait_busy(1'b1);
    pulse();
    repeat (8) @(negedge mclk);
    chk("halted", 16'(st.halted), 16'h1);
    chk("overrun", 16'(ovr), 16'h0);
    wr(16'h0000);
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, well beyond the expected run
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    t_soft();
    t_timer();
    give_verdict();
  end
endmodule
`default_nettype wire
